// file: rtl/hpbl_pkg.sv
// Purpose: shared constants and types for the host port byte-lane block
// Assumes: 32-bit internal locations, 19-bit byte address from the host
// Notes:   data memory window bounds are plain defaults
package hpbl_pkg;

	// ----------------------------------------------------------------
	// widths and pin encodings
	// ----------------------------------------------------------------
	localparam int         ADDR_W       = 19;
	localparam int         WORD_W       = 17;
	localparam int         DATA_W       = 32;
	localparam int         HALF_W       = 16;
	localparam int         LANES        = 4;
	localparam logic       PW_32        = 1'h0;
	localparam logic       PW_16        = 1'h1;
	localparam logic       BS_STROBE    = 1'h0;
	localparam logic       BS_BYTE_EN   = 1'h1;
	localparam logic [1:0] SIZ_FOUR     = 2'h0;
	localparam logic [1:0] SIZ_ONE      = 2'h1;
	localparam logic [1:0] SIZ_NONE_16  = 2'h3;
	localparam logic [3:0] BE_ALL       = 4'hf;
	localparam logic [3:0] BE_NONE      = 4'h0;
	localparam logic [2:0] CNT_FOUR     = 3'h4;
	localparam logic [DATA_W-1:0] OE_ALL      = 32'hffffffff;
	localparam logic [DATA_W-1:0] OE_LOW_HALF = 32'h0000ffff;

	// ----------------------------------------------------------------
	// read-only input data memory window, word addresses
	// ----------------------------------------------------------------
	localparam logic [WORD_W-1:0] DMEM_FIRST = 17'h00000;
	localparam logic [WORD_W-1:0] DMEM_LAST  = 17'h07fff;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              width16;
		logic              byte_style;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [1:0]        siz;
	} hpbl_host_ctl_t;

	typedef struct packed {
		logic              we;
		logic [WORD_W-1:0] addr;
		logic [LANES-1:0]  be;
		logic [DATA_W-1:0] wdata;
	} hpbl_int_cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h1,
		ST_ACCESS = 3'h2,
		ST_DONE   = 3'h4
	} hpbl_state_t;

endpackage : hpbl_pkg

// file: rtl/hpbl_sync.sv
// Purpose: two-stage synchroniser for the asynchronous host strobes
// Assumes: inputs are active low and idle high
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module hpbl_sync (
	input  wire logic       i_mclk,
	input  wire logic       i_srst,
	input  wire logic [1:0] i_async,
	output logic      [1:0] o_sync
);
	import hpbl_pkg::*;

	logic [1:0] meta_r;
	logic [1:0] sync_r;

	// ----------------------------------------------------------------
	// two flops per input
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			meta_r <= 2'h3;
			sync_r <= 2'h3;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;

endmodule : hpbl_sync

// file: rtl/hpbl_lane_decode.sv
// Purpose: byte-lane decode and data steering for one host access
// Assumes: ctl holds the width, style, address and size of the access
// Notes:   purely combinational
`timescale 1ns/10ps
module hpbl_lane_decode (
	input  wire hpbl_pkg::hpbl_host_ctl_t  i_ctl,
	input  wire logic [31:0]               i_bus_data,
	input  wire logic [31:0]               i_word_rdata,
	output logic      [3:0]                o_be,
	output logic                           o_no_access,
	output logic      [31:0]               o_wdata,
	output logic      [31:0]               o_rdata_bus,
	output logic      [31:0]               o_oe_mask
);
	import hpbl_pkg::*;

	// ----------------------------------------------------------------
	// strobe-style mask: start byte plus byte count, msb lane first
	// ----------------------------------------------------------------
	function automatic logic [3:0] strobe_mask(input logic [1:0] start, input logic [1:0] siz);
		logic [3:0] m;
		logic [2:0] cnt;
		logic [2:0] idx;
		m   = BE_NONE;
		cnt = (siz == SIZ_FOUR) ? CNT_FOUR : {1'h0, siz};
		for (int i = 0; i < LANES; i++) begin
			idx = 3'(i);
			if (idx >= {1'h0, start} && idx < ({1'h0, start} + cnt)) begin
				m[3 - i] = 1'h1;
			end
		end
		return m;
	endfunction : strobe_mask

	wire logic [1:0] lanes16_w = ~i_ctl.siz;
	wire logic [3:0] be16_w    = i_ctl.addr[1] ? {2'h0, lanes16_w} : {lanes16_w, 2'h0};
	wire logic [3:0] be32_w    = (i_ctl.byte_style == BS_BYTE_EN)
	                             ? ~{i_ctl.addr[1:0], i_ctl.siz}
	                             : strobe_mask(i_ctl.addr[1:0], i_ctl.siz);
	wire logic [3:0] be_sel_w  = (i_ctl.width16 == PW_16) ? be16_w : be32_w;

	assign o_be        = i_ctl.rd ? BE_ALL : be_sel_w;
	assign o_no_access = (i_ctl.width16 == PW_16) && (i_ctl.siz == SIZ_NONE_16);
	assign o_wdata     = (i_ctl.width16 == PW_16)
	                     ? {i_bus_data[15:0], i_bus_data[15:0]}
	                     : i_bus_data;
	assign o_rdata_bus = (i_ctl.width16 == PW_16)
	                     ? {16'h0000, (i_ctl.addr[1] ? i_word_rdata[15:0]
	                                                 : i_word_rdata[31:16])}
	                     : i_word_rdata;
	assign o_oe_mask   = (i_ctl.width16 == PW_16) ? OE_LOW_HALF : OE_ALL;

endmodule : hpbl_lane_decode

// file: rtl/hpbl_host_port.sv
// Purpose: host processor port, byte-lane decode and cycle handshake
// Assumes: internal side answers each request with i_int_ack
// Notes:   data, acknowledge and bus error pins are split into out/oe
`timescale 1ns/10ps

// Behaviour
// - width pin picks 32 or 16 bit bus
// - style pin picks strobe or byte-enable decode
// - 19-bit byte address, four bytes per word
// - lowest byte address is bits 31:24
// - 32-bit mode maps data lines straight through
// - strobe mode: low address bits name first byte
// - strobe mode: size inputs give byte count
// - byte-enable mode: four active-low lane enables
// - reads drive all 32 bits (low 16 in 16-bit mode), writes use lanes
// - 16-bit line k feeds bits k and k+16
// - 16-bit size inputs are active-low lane enables
// - address bit one picks upper or lower half
// - both size inputs high: no internal access
// - release wait, then acknowledge or bus error
// - strobe rise clears acknowledge and bus error
// - byte-enable mode always gives acknowledge
// - writes to data memory get bus error
module hpbl_host_port (
	input  wire logic                     i_mclk,
	input  wire logic                     i_srst,
	input  wire logic                     i_port_width_select,
	input  wire logic                     i_bus_style_select,
	input  wire logic [18:0]              i_host_address_lines,
	input  wire logic                     i_size_input_high,
	input  wire logic                     i_size_input_low,
	input  wire logic                     i_cs_n,
	input  wire logic                     i_host_data_strobe_n,
	input  wire logic                     i_rd_wr_n,
	input  wire logic [31:0]              i_host_data_lines,
	output logic      [31:0]              o_host_data_lines,
	output logic      [31:0]              o_host_data_oe,
	output logic                          o_wait_n,
	output logic                          o_transfer_acknowledge_n,
	output logic                          o_bus_error_output_n,
	output logic                          o_handshake_oe,
	output logic                          o_int_req,
	output hpbl_pkg::hpbl_int_cmd_t       o_int_cmd,
	input  wire logic                     i_int_ack,
	input  wire logic                     i_int_err,
	input  wire logic [31:0]              i_int_rdata
);
	import hpbl_pkg::*;

	// ----------------------------------------------------------------
	// strobe synchronisers
	// ----------------------------------------------------------------
	logic [1:0] strobes_s;

	hpbl_sync u_sync (
		.i_mclk  (i_mclk),
		.i_srst  (i_srst),
		.i_async ({i_cs_n, i_host_data_strobe_n}),
		.o_sync  (strobes_s)
	);

	wire logic cs_n_s   = strobes_s[1];
	wire logic hstb_n_s = strobes_s[0];
	wire logic sel_w    = !cs_n_s && !hstb_n_s;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	hpbl_state_t    state_r;
	hpbl_state_t    state_nxt;
	hpbl_host_ctl_t ctl_r;
	logic           err_r;
	logic           drive_r;
	logic           req_r;
	hpbl_int_cmd_t  cmd_r;
	logic [31:0]    rdata_r;
	logic [31:0]    oe_mask_r;

	// ----------------------------------------------------------------
	// decode of live pins while idle, captured access afterwards
	// ----------------------------------------------------------------
	wire hpbl_host_ctl_t pin_ctl_w = '{
		width16:    i_port_width_select,
		byte_style: i_bus_style_select,
		rd:         i_rd_wr_n,
		addr:       i_host_address_lines,
		siz:        {i_size_input_high, i_size_input_low}
	};
	wire logic           idle_w    = (state_r == ST_IDLE);
	wire hpbl_host_ctl_t dec_ctl_w = idle_w ? pin_ctl_w : ctl_r;

	logic [3:0]  dec_be;
	logic        dec_none;
	logic [31:0] dec_wdata;
	logic [31:0] dec_rdata;
	logic [31:0] dec_oe;

	hpbl_lane_decode u_dec (
		.i_ctl        (dec_ctl_w),
		.i_bus_data   (i_host_data_lines),
		.i_word_rdata (i_int_rdata),
		.o_be         (dec_be),
		.o_no_access  (dec_none),
		.o_wdata      (dec_wdata),
		.o_rdata_bus  (dec_rdata),
		.o_oe_mask    (dec_oe)
	);

	// word address drops the two byte bits
	wire logic [WORD_W-1:0] word_addr_w = pin_ctl_w.addr[ADDR_W-1:2];
	wire logic dmem_hit_w  = (word_addr_w - DMEM_FIRST) <= (DMEM_LAST - DMEM_FIRST);
	wire logic bad_wr_w    = !pin_ctl_w.rd && dmem_hit_w;
	wire logic start_w     = idle_w && sel_w;
	wire logic issue_w     = start_w && !dec_none && !bad_wr_w;
	wire logic ack_w       = (state_r == ST_ACCESS) && i_int_ack;

	// ----------------------------------------------------------------
	// cycle sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_w) begin
					state_nxt = issue_w ? ST_ACCESS : ST_DONE;
				end
			end
			ST_ACCESS: begin
				if (i_int_ack) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				if (hstb_n_s) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------------------------------
	// captured access and outcome
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			ctl_r <= '0;
			err_r <= 1'h0;
		end else if (start_w) begin
			ctl_r <= pin_ctl_w;
			err_r <= bad_wr_w && !dec_none;
		end else if (ack_w) begin
			err_r <= i_int_err;
		end
	end

	// ----------------------------------------------------------------
	// internal request, one-cycle pulse
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			req_r <= 1'h0;
			cmd_r <= '0;
		end else begin
			req_r <= issue_w;
			if (issue_w) begin
				cmd_r <= '{we: !pin_ctl_w.rd, addr: word_addr_w,
				           be: dec_be, wdata: dec_wdata};
			end
		end
	end

	// ----------------------------------------------------------------
	// read data, held on the bus until select goes away
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			rdata_r   <= '0;
			oe_mask_r <= '0;
			drive_r   <= 1'h0;
		end else begin
			if (ack_w && ctl_r.rd) begin
				rdata_r   <= dec_rdata;
				oe_mask_r <= dec_oe;
				drive_r   <= 1'h1;
			end else if (cs_n_s) begin
				drive_r <= 1'h0;
			end
		end
	end

	assign o_int_req         = req_r;
	assign o_int_cmd         = cmd_r;
	assign o_host_data_lines = rdata_r;
	assign o_host_data_oe    = drive_r ? oe_mask_r : '0;

	// ----------------------------------------------------------------
	// handshake pins
	// ----------------------------------------------------------------
	wire logic done_w = (state_r == ST_DONE);
	assign o_wait_n = !(start_w || (state_r == ST_ACCESS));
	assign o_transfer_acknowledge_n =
		!(done_w && (!err_r || ctl_r.byte_style == BS_BYTE_EN));
	assign o_bus_error_output_n = !(done_w && err_r);
	assign o_handshake_oe = !cs_n_s;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_sync_delay;
		@(posedge i_mclk) disable iff (i_srst)
		o_int_req |-> !$past(i_host_data_strobe_n, 3) && !$past(i_cs_n, 3);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("request before strobe sync");

	property p_read_full;
		@(posedge i_mclk) disable iff (i_srst)
		o_int_req && !o_int_cmd.we |-> o_int_cmd.be == BE_ALL;
	endproperty
	a_read_full: assert property (p_read_full) else $error("read without all lanes");

	property p_wdata_direct;
		@(posedge i_mclk) disable iff (i_srst)
		o_int_req && o_int_cmd.we && !ctl_r.width16
		|-> o_int_cmd.wdata == $past(i_host_data_lines);
	endproperty
	a_wdata_direct: assert property (p_wdata_direct) else $error("32-bit data not direct");

	property p_wdata_dup;
		@(posedge i_mclk) disable iff (i_srst)
		o_int_req && ctl_r.width16
		|-> o_int_cmd.wdata[31:16] == $past(i_host_data_lines[15:0])
		    && o_int_cmd.wdata[15:0] == $past(i_host_data_lines[15:0]);
	endproperty
	a_wdata_dup: assert property (p_wdata_dup) else $error("16-bit data not duplicated");

	property p_half_select;
		@(posedge i_mclk) disable iff (i_srst)
		o_int_req && o_int_cmd.we && ctl_r.width16
		|-> (ctl_r.addr[1] ? o_int_cmd.be[3:2] == 2'h0 : o_int_cmd.be[1:0] == 2'h0);
	endproperty
	a_half_select: assert property (p_half_select) else $error("wrong half word");

	property p_byte_en;
		@(posedge i_mclk) disable iff (i_srst)
		o_int_req && o_int_cmd.we && !ctl_r.width16 && ctl_r.byte_style
		|-> o_int_cmd.be == ~{ctl_r.addr[1:0], ctl_r.siz};
	endproperty
	a_byte_en: assert property (p_byte_en) else $error("byte enables misdecoded");

	property p_one_byte;
		@(posedge i_mclk) disable iff (i_srst)
		o_int_req && o_int_cmd.we && !ctl_r.width16 && !ctl_r.byte_style
		&& ctl_r.siz == SIZ_ONE |-> $onehot(o_int_cmd.be)
		&& o_int_cmd.be[3 - ctl_r.addr[1:0]];
	endproperty
	a_one_byte: assert property (p_one_byte) else $error("single byte misplaced");

	property p_no_access;
		@(posedge i_mclk) disable iff (i_srst)
		start_w && pin_ctl_w.width16 && pin_ctl_w.siz == SIZ_NONE_16
		|=> !o_int_req && done_w && !err_r;
	endproperty
	a_no_access: assert property (p_no_access) else $error("access with no lanes");

	property p_dmem_write;
		@(posedge i_mclk) disable iff (i_srst)
		start_w && bad_wr_w && !dec_none |=> !o_int_req && !o_bus_error_output_n;
	endproperty
	a_dmem_write: assert property (p_dmem_write) else $error("data memory write passed");

	sequence s_acked;
		(state_r == ST_ACCESS) && i_int_ack;
	endsequence
	sequence s_answered;
		o_wait_n && (!o_transfer_acknowledge_n || !o_bus_error_output_n);
	endsequence
	property p_answer;
		@(posedge i_mclk) disable iff (i_srst)
		s_acked |=> s_answered;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer after access");

	property p_be_style_ack;
		@(posedge i_mclk) disable iff (i_srst)
		!o_bus_error_output_n && ctl_r.byte_style |-> !o_transfer_acknowledge_n;
	endproperty
	a_be_style_ack: assert property (p_be_style_ack) else $error("bus error without ack");

	property p_release;
		@(posedge i_mclk) disable iff (i_srst)
		done_w && hstb_n_s |=> o_transfer_acknowledge_n && o_bus_error_output_n;
	endproperty
	a_release: assert property (p_release) else $error("answer held after strobe");

	property p_upper_quiet;
		@(posedge i_mclk) disable iff (i_srst)
		ctl_r.width16 && !idle_w |-> o_host_data_oe[31:16] == 16'h0000;
	endproperty
	a_upper_quiet: assert property (p_upper_quiet) else $error("upper lines driven");

endmodule : hpbl_host_port

// file: sim/hpbl_host_model.sv
// Purpose: host processor model for the byte-lane host port
// Assumes: one bus cycle at a time, pins changed 1 ns after a clock edge
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/10ps
module hpbl_host_model (
	input  wire logic        i_mclk,
	input  wire logic        i_ack_n,
	input  wire logic        i_buserr_n,
	input  wire logic        i_hs_oe,
	input  wire logic        i_wait_n,
	input  wire logic [31:0] i_rdata,
	input  wire logic [31:0] i_oe,
	output logic             o_cs_n,
	output logic             o_hstb_n,
	output logic             o_rd_wr_n,
	output logic             o_w16,
	output logic             o_style,
	output logic      [18:0] o_addr,
	output logic      [1:0]  o_siz,
	output logic      [31:0] o_data
);
	initial begin
		o_cs_n = 1'b1;
		o_hstb_n = 1'b1;
		o_rd_wr_n = 1'b1;
		o_w16 = 1'b0;
		o_style = 1'b0;
		o_addr = 19'h00000;
		o_siz = 2'h0;
		o_data = 32'h00000000;
	end

	// ----------------------------------------------------------------
	// one bus cycle; st = {ok, wait seen low then released, bus error, acknowledge}
	// ----------------------------------------------------------------
	task automatic cycle(input logic m16, input logic sty, input logic rd,
			input logic [18:0] a, input logic [1:0] s, input logic [31:0] wd,
			output logic [3:0] st, output logic [31:0] rv, output logic [31:0] ov);
		int n;
		logic wl;
		st = 4'h0;
		rv = 32'h0;
		ov = 32'h0;
		wl = 1'b0;
		@(posedge i_mclk);
		#1;
		o_w16 = m16;
		o_style = sty;
		o_rd_wr_n = rd;
		o_addr = a;
		o_siz = s;
		o_data = m16 ? {16'h5a5a, wd[15:0]} : wd;
		o_cs_n = 1'b0;
		o_hstb_n = 1'b0;
		for (n = 0; n < 200 && !st[3]; n++) begin
			@(posedge i_mclk);
			if (i_wait_n === 1'b0) begin
				wl = 1'b1;
			end
			if (i_hs_oe === 1'b1 && (i_ack_n === 1'b0 || i_buserr_n === 1'b0)) begin
				st = {1'b1, i_wait_n === 1'b1 && wl, ~i_buserr_n, ~i_ack_n};
				rv = i_rdata;
				ov = i_oe;
			end
		end
		#1;
		o_hstb_n = 1'b1;
		for (n = 0; n < 8 && (i_ack_n !== 1'b1 || i_buserr_n !== 1'b1); n++) begin
			@(posedge i_mclk);
		end
		if (n > 5) st[3] = 1'b0;
		@(posedge i_mclk);
		#1;
		o_cs_n = 1'b1;
		o_data = ~o_data;
		repeat (3) @(posedge i_mclk);
		#1;
	endtask : cycle
endmodule : hpbl_host_model

// file: sim/tb_hpbl_host_port.sv
// Purpose: self-checking bench for the host port byte-lane block
// Assumes: internal side answered by a small responder with set latency
// Notes:   status word is {ok, wait low then released, bus error, acknowledge}
`timescale 1ns/10ps
module tb_hpbl_host_port;
	import hpbl_pkg::*;
	logic          i_mclk, i_srst, cs_n, hstb_n, rw_n, w16, sty;
	logic          wait_n, ack_n, buserr_n, hs_oe, int_req, int_ack, int_err;
	logic [18:0]   addr;
	logic [1:0]    siz;
	logic [31:0]   hdata, dout, doe, int_rdata;
	hpbl_int_cmd_t cmd, cmd_seen;
	int            fail_count, comparisons, req_cnt, lat, cnt, cycles;
	logic [3:0]    st;
	logic [31:0]   rv, ov;

	hpbl_host_port hpbl_host_port_inst (
		.i_mclk(i_mclk), .i_srst(i_srst), .i_port_width_select(w16),
		.i_bus_style_select(sty), .i_host_address_lines(addr),
		.i_size_input_high(siz[1]), .i_size_input_low(siz[0]),
		.i_cs_n(cs_n), .i_host_data_strobe_n(hstb_n), .i_rd_wr_n(rw_n),
		.i_host_data_lines(hdata), .o_host_data_lines(dout), .o_host_data_oe(doe),
		.o_wait_n(wait_n), .o_transfer_acknowledge_n(ack_n),
		.o_bus_error_output_n(buserr_n), .o_handshake_oe(hs_oe), .o_int_req(int_req),
		.o_int_cmd(cmd), .i_int_ack(int_ack), .i_int_err(int_err),
		.i_int_rdata(int_rdata)
	);

	hpbl_host_model hpbl_host_model_inst (
		.i_mclk(i_mclk), .i_ack_n(ack_n), .i_buserr_n(buserr_n), .i_hs_oe(hs_oe),
		.i_wait_n(wait_n), .i_rdata(dout), .i_oe(doe), .o_cs_n(cs_n),
		.o_hstb_n(hstb_n), .o_rd_wr_n(rw_n), .o_w16(w16), .o_style(sty),
		.o_addr(addr), .o_siz(siz), .o_data(hdata)
	);

	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	// ----------------------------------------------------------------
	// internal responder and run limit
	// ----------------------------------------------------------------
	always @(posedge i_mclk) begin
		int_ack <= 1'b0;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			give_verdict();
		end
		if (int_req === 1'b1) begin
			cmd_seen <= cmd;
			req_cnt <= req_cnt + 1;
			cnt <= lat;
		end else if (cnt == 1) begin
			int_ack <= 1'b1;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	function automatic logic [3:0] be_strobe(input logic [1:0] a, input logic [1:0] s);
		int n;
		logic [3:0] b;
		n = (s == 2'h0) ? 4 : int'(s);
		b = 4'h0;
		for (int k = 0; k < 4; k++) begin
			if (k >= int'(a) && k < int'(a) + n) b[3-k] = 1'b1;
		end
		return b;
	endfunction : be_strobe

	task automatic cmd_chk(input logic rd, input logic [16:0] w, input logic [3:0] be);
		chk("we", 32'(!rd), 32'(cmd_seen.we));
		chk("word", 32'(w), 32'(cmd_seen.addr));
		chk("lanes", 32'(be), 32'(cmd_seen.be));
	endtask : cmd_chk

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_w32;
		logic [31:0] d;
		logic [3:0]  be;
		for (int i = 0; i < 31; i++) begin
			d = 32'h11223344 ^ 32'(i * 32'h01010101);
			be = i > 15 ? ~i[3:0] : be_strobe(i[3:2], i[1:0]);
			hpbl_host_model_inst.cycle(1'b0, i > 15, 1'b0, {17'h10080, i[3:2]}, i[1:0],
				d, st, rv, ov);
			chk("status", 32'hd, 32'(st));
			cmd_chk(1'b0, 17'h10080, be);
			chk("wdata", d, cmd_seen.wdata);
		end
		chk("requests", 32'd31, 32'(req_cnt));
	endtask : t_w32

	task automatic t_w16;
		logic [3:0] be;
		int rc;
		for (int i = 0; i < 16; i++) begin
			rc = req_cnt;
			be = i[1] ? {2'b00, ~i[3:2]} : {~i[3:2], 2'b00};
			hpbl_host_model_inst.cycle(1'b1, i[0], 1'b0, {17'h10082, i[1], 1'b1}, i[3:2],
				32'h0000c35a ^ 32'(i), st, rv, ov);
			chk("status", 32'hd, 32'(st));
			if (i < 12) begin
				cmd_chk(1'b0, 17'h10082, be);
				chk("wdata", {2{16'hc35a ^ 16'(i)}}, cmd_seen.wdata);
			end else begin
				chk("requests", 32'(rc), 32'(req_cnt));
			end
		end
	endtask : t_w16

	task automatic t_read;
		logic [31:0] r;
		lat = 5;
		for (int i = 0; i < 6; i++) begin
			r = 32'hc0ffee00 ^ 32'(i);
			int_rdata = r;
			hpbl_host_model_inst.cycle(i > 1, i[0], 1'b1, {17'h10083, i[1], 1'b1}, 2'h1,
				32'h0, st, rv, ov);
			chk("status", 32'hd, 32'(st));
			cmd_chk(1'b1, 17'h10083, BE_ALL);
			chk("rdata", i > 1 ? {16'h0, i[1] ? r[15:0] : r[31:16]} : r, rv);
			chk("oe", i > 1 ? OE_LOW_HALF : OE_ALL, ov);
		end
	endtask : t_read

	task automatic t_fault;
		int rc;
		for (int i = 0; i < 4; i++) begin
			rc = req_cnt;
			int_err = i[1];
			hpbl_host_model_inst.cycle(1'b0, i[0], i[1], 19'h00040, 2'h0, 32'h600d600d,
				st, rv, ov);
			chk("status", i[0] ? 32'hf : 32'he, 32'(st));
			chk("requests", 32'(rc + i[1]), 32'(req_cnt));
		end
		int_err = 1'b0;
		// last word inside the read-only window, then the first one outside it
		rc = req_cnt;
		hpbl_host_model_inst.cycle(1'b0, 1'b0, 1'b0, {DMEM_LAST, 2'h0}, 2'h0, 32'h600d600d,
			st, rv, ov);
		chk("status", 32'he, 32'(st));
		hpbl_host_model_inst.cycle(1'b0, 1'b0, 1'b0, {DMEM_LAST + 17'h1, 2'h0}, 2'h0,
			32'h600d600d, st, rv, ov);
		chk("status", 32'hd, 32'(st));
		chk("requests", 32'(rc + 1), 32'(req_cnt));
	endtask : t_fault

	task automatic give_verdict;
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		fail_count = 0;
		comparisons = 0;
		req_cnt = 0;
		cnt = 0;
		cycles = 0;
		lat = 1;
		int_ack = 1'b0;
		int_err = 1'b0;
		int_rdata = 32'h0;
		i_srst = 1'b1;
		repeat (8) @(posedge i_mclk);
		#1;
		i_srst = 1'b0;
		t_w32();
		t_w16();
		t_read();
		t_fault();
		give_verdict();
	end
endmodule : tb_hpbl_host_port
